// ### mxb_defs.svh
// constants for the multiply/divide/xor/branch execute block
// assumes 16-bit words, byte-addressed AHB-Lite register map
// Functional notes
// - signed multiply; even register gets full product in register pair
// - signed multiply on odd register stores only the low product word
// - multiply sets N and Z from product, always clears V
// - multiply sets C when product below -2^15 or at least 2^15-1
// - divide splits 32-bit register pair by source; quotient into even register
// - divide remainder goes to odd partner, carrying the dividend sign
// - divide sets V and aborts on zero divisor or quotient too large
// - divide sets C only on divide by zero, clears it otherwise
// - divide sets N and Z from the quotient
// - xor writes register xor destination to the result word, and to the destination register only when mode bits 5:3 are 0; register kept
// - xor sets N and Z from result, clears V, leaves C
// - unconditional jump adds twice offset to PC; flags untouched
// - jump if nonzero taken only when Z clear
// - jump if equal taken only when Z set
// - signed not-less jump taken when N equals V
`ifndef MXB_DEFS_SVH
`define MXB_DEFS_SVH
`define MXB_OFF_INSTR 8'h00
`define MXB_OFF_SRC 8'h04
`define MXB_OFF_PC 8'h08
`define MXB_OFF_PSW 8'h0C
`define MXB_OFF_STAT 8'h10
`define MXB_OFF_RES 8'h14
`define MXB_REG_BANK 3'h1
`define MXB_BIT_N 3
`define MXB_BIT_Z 2
`define MXB_BIT_V 1
`define MXB_BIT_C 0
`define MXB_RST_PSW 4'h0
`define MXB_RST_PC 16'h0000
`define MXB_RST_WORD 16'h0000
`define MXB_OPC_MUL 7'h38
`define MXB_OPC_DIV 7'h39
`define MXB_OPC_XOR 7'h3C
`define MXB_OPC_JMP 8'h01
`define MXB_OPC_JNZ 8'h02
`define MXB_OPC_JEQ 8'h03
`define MXB_OPC_JGE 8'h04
`define MXB_MUL_LO 32'shFFFF8000
`define MXB_MUL_HI 32'sh00007FFF
`define MXB_QPOS_MAX 32'h00007FFF
`define MXB_QNEG_MAX 32'h00008000
`define MXB_HSIZE_WORD 3'h2
`endif

// ### mxb_pkg.sv
// types shared by the execute block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package mxb_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DIVW} mxb_state_t;
   typedef enum logic [2:0] {OP_NONE, OP_MUL, OP_DIV, OP_XOR, OP_JMP, OP_JNZ, OP_JEQ, OP_JGE} mxb_op_t;
endpackage : mxb_pkg
`default_nettype wire

// ### mxb_div.sv
// unsigned restoring divider, one quotient bit per clock
// assumes start only while idle; operands held by caller
`default_nettype none
module mxb_div #(
   parameter int DW = 32,
   parameter int VW = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic [DW-1:0] dividend,
   input wire logic [VW-1:0] divisor,
   output logic done_q,
   output logic [DW-1:0] quo_q,
   output logic [VW-1:0] rem_q
);
   logic [$clog2(DW+1)-1:0] cnt_q;
   logic [VW:0] shifted;
   logic [VW:0] diff;
   logic ge;

   always_comb
   begin
      shifted = {rem_q, quo_q[DW-1]};
      diff = shifted - {1'b0, divisor};
      ge = shifted >= {1'b0, divisor};
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_q <= '0;
         quo_q <= '0;
         rem_q <= '0;
         done_q <= 1'b0;
      end
      else if (start)
      begin
         cnt_q <= ($clog2(DW+1))'(DW);
         quo_q <= dividend;
         rem_q <= '0;
         done_q <= 1'b0;
      end
      else if (cnt_q != '0)
      begin
         cnt_q <= cnt_q - 1'b1;
         quo_q <= {quo_q[DW-2:0], ge};
         rem_q <= ge ? diff[VW-1:0] : shifted[VW-1:0];
         done_q <= (cnt_q == 1'b1);
      end
      else
      begin
         done_q <= 1'b0;
      end
   end
endmodule : mxb_div
`default_nettype wire

// ### mxb_exec.sv
// execute block: signed multiply, signed divide, xor, four relative jumps
// assumes one AHB-Lite master, single word transfers, hready fed back from hreadyout
`include "mxb_defs.svh"
`default_nettype none
module mxb_exec (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   mxb_pkg::mxb_state_t st_q;
   mxb_pkg::mxb_op_t op;
   logic [15:0] regs_q [8];
   logic [15:0] instr_q, src_q, pc_q, res_q;
   logic [3:0] psw_q;
   logic taken_q, abort_q, illegal_q;
   logic [7:0] addr_q;
   logic wr_q, rd_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q, hresp_q;
   logic acc, wr_ok, go;
   logic [2:0] r, rp, sd;
   logic signed [31:0] prod;
   logic mul_c;
   logic [15:0] dst_val, xres, off, target;
   logic take;
   logic dd_neg, dv_neg, div_zero, div_big, div_start, div_done, fit;
   logic [31:0] dd_mag, quo_mag, q_signed;
   logic [15:0] dv_mag, hi_mag, rem_mag, rem_signed;

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;

   function automatic logic is_reg(input logic [7:0] a);
      return a[7:5] == `MXB_REG_BANK;
   endfunction : is_reg

   function automatic mxb_pkg::mxb_op_t decode_op(input logic [15:0] w);
      if (w[15:9] == `MXB_OPC_MUL)
         return mxb_pkg::OP_MUL;
      if (w[15:9] == `MXB_OPC_DIV)
         return mxb_pkg::OP_DIV;
      if (w[15:9] == `MXB_OPC_XOR)
         return mxb_pkg::OP_XOR;
      if (w[15:8] == `MXB_OPC_JMP)
         return mxb_pkg::OP_JMP;
      if (w[15:8] == `MXB_OPC_JNZ)
         return mxb_pkg::OP_JNZ;
      if (w[15:8] == `MXB_OPC_JEQ)
         return mxb_pkg::OP_JEQ;
      if (w[15:8] == `MXB_OPC_JGE)
         return mxb_pkg::OP_JGE;
      return mxb_pkg::OP_NONE;
   endfunction : decode_op

   function automatic logic [31:0] read_word(input logic [7:0] a);
      if (is_reg(a))
         return {16'h0000, regs_q[a[4:2]]};
      case (a)
         `MXB_OFF_INSTR: return {16'h0000, instr_q};
         `MXB_OFF_SRC: return {16'h0000, src_q};
         `MXB_OFF_PC: return {16'h0000, pc_q};
         `MXB_OFF_PSW: return {28'h0000000, psw_q};
         `MXB_OFF_STAT: return {28'h0000000, illegal_q, abort_q, taken_q, st_q != mxb_pkg::ST_IDLE};
         `MXB_OFF_RES: return {16'h0000, res_q};
         default: return 32'h00000000;
      endcase
   endfunction : read_word

   // bus slave: reads take one wait state so hrdata comes from a flop
   assign acc = hsel && htrans[1] && hready;
   assign wr_ok = wr_q && (st_q == mxb_pkg::ST_IDLE);
   assign go = wr_ok && (addr_q == `MXB_OFF_INSTR);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         addr_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         hreadyout_q <= 1'b1;
         hrdata_q <= 32'h00000000;
         hresp_q <= 1'b0;
      end
      else
      begin
         hresp_q <= 1'b0;
         if (acc)
         begin
            addr_q <= haddr[7:0];
            wr_q <= hwrite && (hsize == `MXB_HSIZE_WORD);
            rd_q <= !hwrite;
            hreadyout_q <= hwrite;
         end
         else
         begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            hreadyout_q <= 1'b1;
         end
         if (rd_q)
            hrdata_q <= read_word(addr_q);
      end
   end

   // instruction field decode
   always_comb
   begin
      op = decode_op(instr_q);
      r = instr_q[8:6];
      rp = r | 3'h1;
      sd = instr_q[2:0];
   end

   // multiply and xor datapath
   assign prod = $signed(regs_q[r]) * $signed(src_q);
   assign mul_c = (prod < `MXB_MUL_LO) || (prod >= `MXB_MUL_HI);
   assign dst_val = (instr_q[5:3] == 3'h0) ? regs_q[sd] : src_q;
   assign xres = regs_q[r] ^ dst_val;

   // jump target and condition
   assign off = {{8{instr_q[7]}}, instr_q[7:0]};
   assign target = pc_q + {off[14:0], 1'b0};

   always_comb
   begin
      case (op)
         mxb_pkg::OP_JMP: take = 1'b1;
         mxb_pkg::OP_JNZ: take = !psw_q[`MXB_BIT_Z];
         mxb_pkg::OP_JEQ: take = psw_q[`MXB_BIT_Z];
         mxb_pkg::OP_JGE: take = !(psw_q[`MXB_BIT_N] ^ psw_q[`MXB_BIT_V]);
         default: take = 1'b0;
      endcase
   end

   // divide: magnitudes in, signs restored after
   always_comb
   begin
      dd_neg = regs_q[r][15];
      dv_neg = src_q[15];
      dd_mag = dd_neg ? 32'h00000000 - {regs_q[r], regs_q[rp]} : {regs_q[r], regs_q[rp]};
      dv_mag = dv_neg ? 16'h0000 - src_q : src_q;
      hi_mag = dd_neg ? 16'h0000 - regs_q[r] : regs_q[r];
      div_zero = src_q == 16'h0000;
      div_big = hi_mag > dv_mag;
      div_start = (st_q == mxb_pkg::ST_EXEC) && (op == mxb_pkg::OP_DIV) && !div_zero && !div_big;
      q_signed = (dd_neg ^ dv_neg) ? 32'h00000000 - quo_mag : quo_mag;
      fit = (dd_neg ^ dv_neg) ? (quo_mag <= `MXB_QNEG_MAX) : (quo_mag <= `MXB_QPOS_MAX);
      rem_signed = dd_neg ? 16'h0000 - rem_mag : rem_mag;
   end

   mxb_div #(
      .DW(32),
      .VW(16)
   ) u_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(div_start),
      .dividend(dd_mag),
      .divisor(dv_mag),
      .done_q(div_done),
      .quo_q(quo_mag),
      .rem_q(rem_mag)
   );

   // sequencing; bus writes are ignored while busy
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_q <= mxb_pkg::ST_IDLE;
      else
      begin
         case (st_q)
            mxb_pkg::ST_IDLE: st_q <= go ? mxb_pkg::ST_EXEC : mxb_pkg::ST_IDLE;
            mxb_pkg::ST_EXEC: st_q <= div_start ? mxb_pkg::ST_DIVW : mxb_pkg::ST_IDLE;
            mxb_pkg::ST_DIVW: st_q <= div_done ? mxb_pkg::ST_IDLE : mxb_pkg::ST_DIVW;
            default: st_q <= mxb_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         instr_q <= `MXB_RST_WORD;
         src_q <= `MXB_RST_WORD;
      end
      else
      begin
         if (go)
            instr_q <= hwdata[15:0];
         if (wr_ok && addr_q == `MXB_OFF_SRC)
            src_q <= hwdata[15:0];
      end
   end

   // general registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < 8; i++)
            regs_q[i] <= `MXB_RST_WORD;
      end
      else if (wr_ok && is_reg(addr_q))
         regs_q[addr_q[4:2]] <= hwdata[15:0];
      else if (st_q == mxb_pkg::ST_EXEC && op == mxb_pkg::OP_MUL)
      begin
         if (!r[0])
         begin
            regs_q[r] <= prod[31:16];
            regs_q[rp] <= prod[15:0];
         end
         else
            regs_q[r] <= prod[15:0];
      end
      else if (st_q == mxb_pkg::ST_EXEC && op == mxb_pkg::OP_XOR && instr_q[5:3] == 3'h0)
         regs_q[sd] <= xres;
      else if (st_q == mxb_pkg::ST_DIVW && div_done && fit)
      begin
         regs_q[rp] <= rem_signed;
         regs_q[r] <= q_signed[15:0];
      end
   end

   // condition bits
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         psw_q <= `MXB_RST_PSW;
      else if (wr_ok && addr_q == `MXB_OFF_PSW)
         psw_q <= hwdata[3:0];
      else if (st_q == mxb_pkg::ST_EXEC)
      begin
         case (op)
            mxb_pkg::OP_MUL:
            begin
               psw_q[`MXB_BIT_N] <= prod[31];
               psw_q[`MXB_BIT_Z] <= prod == 32'sh00000000;
               psw_q[`MXB_BIT_V] <= 1'b0;
               psw_q[`MXB_BIT_C] <= mul_c;
            end
            mxb_pkg::OP_DIV:
            begin
               if (div_zero || div_big)
               begin
                  psw_q[`MXB_BIT_V] <= 1'b1;
                  psw_q[`MXB_BIT_C] <= div_zero;
               end
            end
            mxb_pkg::OP_XOR:
            begin
               psw_q[`MXB_BIT_N] <= xres[15];
               psw_q[`MXB_BIT_Z] <= xres == 16'h0000;
               psw_q[`MXB_BIT_V] <= 1'b0;
            end
            default: psw_q <= psw_q;
         endcase
      end
      else if (st_q == mxb_pkg::ST_DIVW && div_done)
      begin
         psw_q[`MXB_BIT_C] <= 1'b0;
         psw_q[`MXB_BIT_V] <= !fit;
         if (fit)
         begin
            psw_q[`MXB_BIT_N] <= q_signed[15];
            psw_q[`MXB_BIT_Z] <= q_signed[15:0] == 16'h0000;
         end
      end
   end

   // program counter holds the already incremented value
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pc_q <= `MXB_RST_PC;
      else if (wr_ok && addr_q == `MXB_OFF_PC)
         pc_q <= hwdata[15:0];
      else if (st_q == mxb_pkg::ST_EXEC && take)
         pc_q <= target;
   end

   // result and status
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         res_q <= `MXB_RST_WORD;
         taken_q <= 1'b0;
         abort_q <= 1'b0;
         illegal_q <= 1'b0;
      end
      else if (st_q == mxb_pkg::ST_EXEC)
      begin
         taken_q <= take;
         abort_q <= (op == mxb_pkg::OP_DIV) && (div_zero || div_big);
         illegal_q <= op == mxb_pkg::OP_NONE;
         if (op == mxb_pkg::OP_XOR)
            res_q <= xres;
         else if (op == mxb_pkg::OP_MUL)
            res_q <= prod[15:0];
      end
      else if (st_q == mxb_pkg::ST_DIVW && div_done)
      begin
         abort_q <= !fit;
         if (fit)
            res_q <= q_signed[15:0];
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_exec(mxb_pkg::mxb_op_t o);
      st_q == mxb_pkg::ST_EXEC && op == o;
   endsequence

   sequence s_div_run;
      st_q == mxb_pkg::ST_DIVW ##[1:39] st_q == mxb_pkg::ST_IDLE;
   endsequence

   AST_MUL_EVEN: assert property (s_exec(mxb_pkg::OP_MUL) and !r[0] |=> regs_q[$past(r)] == $past(prod[31:16]))
      else $error("even multiply high word wrong");
   AST_MUL_ODD: assert property (s_exec(mxb_pkg::OP_MUL) and r[0] |=> regs_q[$past(r)] == $past(prod[15:0]))
      else $error("odd multiply word wrong");
   AST_MUL_FLAGS: assert property (s_exec(mxb_pkg::OP_MUL) |=> !psw_q[`MXB_BIT_V] && psw_q[`MXB_BIT_N] == $past(prod[31]))
      else $error("multiply N or V wrong");
   AST_MUL_C: assert property (s_exec(mxb_pkg::OP_MUL) |=> psw_q[`MXB_BIT_C] == $past(mul_c))
      else $error("multiply carry wrong");
   AST_DIV_ZERO: assert property (s_exec(mxb_pkg::OP_DIV) and div_zero |=> psw_q[`MXB_BIT_V] && psw_q[`MXB_BIT_C] && st_q == mxb_pkg::ST_IDLE)
      else $error("divide by zero not flagged");
   AST_DIV_END: assert property (div_start |=> s_div_run)
      else $error("divide did not finish in time");
   AST_DIV_OK: assert property (st_q == mxb_pkg::ST_DIVW && div_done && fit |=> !psw_q[`MXB_BIT_V] && !psw_q[`MXB_BIT_C])
      else $error("divide flags wrong");
   AST_XOR_C: assert property (s_exec(mxb_pkg::OP_XOR) |=> $stable(psw_q[`MXB_BIT_C]) && !psw_q[`MXB_BIT_V])
      else $error("xor carry or overflow wrong");
   AST_JMP_FLAGS: assert property (st_q == mxb_pkg::ST_EXEC && op inside {mxb_pkg::OP_JMP, mxb_pkg::OP_JNZ,
      mxb_pkg::OP_JEQ, mxb_pkg::OP_JGE} |=> $stable(psw_q))
      else $error("jump changed flags");
   AST_JNZ: assert property (s_exec(mxb_pkg::OP_JNZ) |=> pc_q == ($past(psw_q[`MXB_BIT_Z]) ? $past(pc_q) : $past(target)))
      else $error("nonzero jump wrong");
   AST_JEQ: assert property (s_exec(mxb_pkg::OP_JEQ) |=> pc_q == ($past(psw_q[`MXB_BIT_Z]) ? $past(target) : $past(pc_q)))
      else $error("equal jump wrong");
   AST_JGE: assert property (s_exec(mxb_pkg::OP_JGE) and (psw_q[`MXB_BIT_N] == psw_q[`MXB_BIT_V]) |=> pc_q == $past(target))
      else $error("signed not-less jump not taken");
   AST_TARGET: assert property (s_exec(mxb_pkg::OP_JMP) |=> pc_q == $past(pc_q) + {$past(off[14:0]), 1'b0})
      else $error("jump target wrong");
endmodule : mxb_exec
`default_nettype wire

// ### mxb_exec_test.sv
// self-checking bench for the multiply/divide/xor/jump execute block
// assumes the block is the only AHB-Lite slave, its hreadyout fed back as hready
`include "mxb_defs.svh"
`default_nettype none
module mxb_exec_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] OFF_REG = 8'h20;
   // multiply into odd register: operand, source, low product, flags
   localparam logic [63:0] MT [5] = '{
      64'h0003_0004_000C_0000, 64'h7FFF_0001_7FFF_0001, 64'h0005_0000_0000_0004,
      64'hFFFD_2AAB_7FFF_0009, 64'hFFFE_4000_8000_0008};
   // divide: high, low, divisor, quotient, remainder, flags, flag mask
   localparam logic [87:0] DT [5] = '{
      88'h0000_0064_FFF9_FFF2_0002_8_F, 88'hFFFF_FF9C_0007_FFF2_FFFE_8_F,
      88'h0000_0003_0005_0000_0003_4_F, 88'h0000_0005_0000_0000_0005_F_F,
      88'h0010_0000_0002_0010_0000_2_3};
   // jumps: taken, preset flags, instruction word
   localparam logic [23:0] JT [11] = '{
      24'h1_0_017F, 24'h1_0_0180, 24'h1_0_0210, 24'h0_4_0210, 24'h1_4_03F0, 24'h0_0_03F0,
      24'h1_0_0405, 24'h1_A_0405, 24'h0_8_0405, 24'h0_2_0405, 24'h1_4_0405};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   int fails = 0;
   int n_checks = 0;

   mxb_exec mxb_exec_inst (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp)
   );

   always #25 hclk = ~hclk;

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // returns at the edge where hready is sampled high
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 100)
      begin
         @(posedge hclk);
         n++;
      end
      if (hreadyout !== 1'b1)
      begin
         fails++;
         $display("wrong value at %0t ns: hready never returned", $time);
      end
   endtask : wait_ready

   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {16'h0000, wd};
      wait_ready();
      rd = hrdata;
      chk({31'h00000000, hresp}, 32'h00000000, "bus response");
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] unused;
      bus(1'b1, a, d, unused);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] v;
      bus(1'b0, a, 16'h0000, v);
      chk(v, exp, what);
   endtask : rd_chk

   // start an instruction and poll until busy drops
   task automatic exec(input logic [15:0] instr);
      logic [31:0] st;
      int n;
      wr(`MXB_OFF_INSTR, instr);
      n = 0;
      st = 32'h00000001;
      while (st[0] !== 1'b0 && n < 60)
      begin
         bus(1'b0, `MXB_OFF_STAT, 16'h0000, st);
         n++;
      end
      if (st[0] !== 1'b0)
      begin
         fails++;
         $display("wrong value at %0t ns: block stayed busy", $time);
      end
   endtask : exec

   initial
   begin : main
      logic [31:0] v;
      logic [15:0] pc;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(`MXB_OFF_PSW, 32'h00000000, "flags after reset");
      rd_chk(`MXB_OFF_PC, 32'h00000000, "pc after reset");
      rd_chk(8'h40, 32'h00000000, "unmapped read");
      wr(OFF_REG + 8'h08, 16'h012C);
      wr(`MXB_OFF_SRC, 16'hFF38);
      exec(16'h7080);
      rd_chk(OFF_REG + 8'h08, 32'h0000FFFF, "product high word");
      rd_chk(OFF_REG + 8'h0C, 32'h000015A0, "product low word");
      rd_chk(`MXB_OFF_PSW, 32'h00000009, "product flags");
      rd_chk(`MXB_OFF_RES, 32'h000015A0, "product low result");
      wr(OFF_REG + 8'h10, 16'hAAAA);
      for (int i = 0; i < 5; i++)
      begin
         wr(OFF_REG + 8'h14, MT[i][63:48]);
         wr(`MXB_OFF_SRC, MT[i][47:32]);
         exec(16'h7140);
         rd_chk(OFF_REG + 8'h14, {16'h0000, MT[i][31:16]}, "odd product");
         rd_chk(`MXB_OFF_PSW, {16'h0000, MT[i][15:0]}, "odd product flags");
      end
      rd_chk(OFF_REG + 8'h10, 32'h0000AAAA, "neighbour of odd register");
      for (int i = 0; i < 5; i++)
      begin
         wr(OFF_REG, DT[i][87:72]);
         wr(OFF_REG + 8'h04, DT[i][71:56]);
         wr(`MXB_OFF_SRC, DT[i][55:40]);
         wr(`MXB_OFF_PSW, 16'h000C);
         exec(16'h7200);
         rd_chk(OFF_REG, {16'h0000, DT[i][39:24]}, "quotient");
         rd_chk(OFF_REG + 8'h04, {16'h0000, DT[i][23:8]}, "remainder");
         bus(1'b0, `MXB_OFF_PSW, 16'h0000, v);
         chk(v & {28'h0000000, DT[i][3:0]}, {28'h0000000, DT[i][7:4]}, "quotient flags");
         bus(1'b0, `MXB_OFF_STAT, 16'h0000, v);
         chk(v & 32'h00000004, {29'h0000000, DT[i][5], 2'b00}, "divide abort status");
      end
      wr(OFF_REG + 8'h04, 16'h0F0F);
      wr(OFF_REG + 8'h0C, 16'hFF00);
      wr(`MXB_OFF_PSW, 16'h0003);
      exec(16'h7843);
      rd_chk(OFF_REG + 8'h0C, 32'h0000F00F, "xor destination");
      rd_chk(OFF_REG + 8'h04, 32'h00000F0F, "xor register kept");
      rd_chk(`MXB_OFF_PSW, 32'h00000009, "xor flags");
      wr(`MXB_OFF_SRC, 16'h0F0F);
      wr(`MXB_OFF_PSW, 16'h0001);
      exec(16'h7848);
      rd_chk(`MXB_OFF_RES, 32'h00000000, "xor result");
      rd_chk(`MXB_OFF_PSW, 32'h00000005, "xor zero flags");
      for (int i = 0; i < 11; i++)
      begin
         wr(`MXB_OFF_PC, 16'h1000);
         wr(`MXB_OFF_PSW, {12'h000, JT[i][19:16]});
         exec(JT[i][15:0]);
         pc = JT[i][20] ? 16'h1000 + {{7{JT[i][7]}}, JT[i][7:0], 1'b0} : 16'h1000;
         rd_chk(`MXB_OFF_PC, {16'h0000, pc}, "jump target");
         rd_chk(`MXB_OFF_PSW, {28'h0000000, JT[i][19:16]}, "jump keeps flags");
         bus(1'b0, `MXB_OFF_STAT, 16'h0000, v);
         chk(v & 32'h00000002, {30'h0000000, JT[i][20], 1'b0}, "jump taken status");
      end
      exec(16'h0000);
      rd_chk(`MXB_OFF_STAT, 32'h00000008, "unrecognised word status");
      summarize();
   end

   // span well above the whole sequence
   initial
   begin : watchdog
      #1000000;
      fails++;
      summarize();
   end
endmodule : mxb_exec_test
`default_nettype wire
